// *** hdl/crf_core.sv ***
/*
 * crf_core: 32 x 8 working registers, pointer pairs, status flags, fetch
 * pipeline stage and interrupt gating of a small 8-bit harvard cpu.
 * assumes the decoder and alu drive the op and operand ports in step with
 * clock_i and hold ops to one cycle each.
 */
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
// What this block does
// - fetch of next instruction overlaps execution in one pipeline stage
// - thirty-two byte registers, one-cycle read and write
// - two operands out, result written back same cycle
// - six registers pair into three 16-bit data pointers
// - pointer pairs are registers 26 to 31
// - one pointer pair also addresses flash lookup tables
// - flags updated after every alu operation
// - program words are one-word or half of two-word instructions
// - self-write to application section only from boot section
// - return address pushed to data stack on interrupt entry
// - lower vector address wins interrupt priority
// - 64 io locations reachable directly and at data 20h-5Fh
// - extended io 60h-FFh only via data load and store
// - flags not saved or restored by interrupt entry or return
// - global enable clear blocks every interrupt
// - enable cleared on entry, set on return, set/clear instructions
// - bit-copy flag loaded by bit store, copied out by bit load
// - half-carry records carry out of low nibble
// - sign equals negative xor overflow
// - overflow, negative, zero and carry flags reflect results
// - 8/8, 2x8/8, 2x8/16 and 16/16 port configurations
// - registers mapped at data addresses 0 to 31
// - after interrupt return one main instruction runs first
module crf_core (
	input wire logic clock_i,
	input wire logic sys_rst_i,
	// decoder/alu port
	input wire logic [crf_pkg::CRF_AW-1:0] rd_a_sel_i,
	input wire logic [crf_pkg::CRF_AW-1:0] rd_b_sel_i,
	output logic [7:0] rd_a_o,
	output logic [7:0] rd_b_o,
	output logic [15:0] rd_word_o,
	input wire logic [crf_pkg::CRF_AW-1:0] wb_sel_i,
	input wire logic wb_en_i,
	input wire logic wb_word_i,
	input wire logic [15:0] wb_data_i,
	input wire logic alu_op_i,
	input wire logic [7:0] alu_flags_i,
	input wire logic [7:0] alu_flag_mask_i,
	input wire logic bit_store_to_flag_op_i,
	input wire logic bit_load_from_flag_op_i,
	input wire logic [2:0] bit_sel_i,
	input wire logic set_global_irq_op_i,
	input wire logic clear_global_irq_op_i,
	input wire logic return_from_irq_op_i,
	// pointers
	output logic [15:0] ptr_x_o,
	output logic [15:0] ptr_y_o,
	output logic [15:0] ptr_z_o,
	// fetch stage
	input wire logic fetch_en_i,
	input wire logic [15:0] prog_word_i,
	output logic [15:0] instr_o,
	output logic instr_valid_o,
	input wire logic [15:0] program_counter_i,
	input wire logic [15:0] boot_start_i,
	input wire logic flash_self_write_op_i,
	input wire logic [15:0] flash_target_i,
	output logic flash_write_go_o,
	output logic [15:0] stack_push_pc_o,
	output logic stack_push_o,
	// interrupts
	input wire logic [crf_pkg::CRF_NIRQ-1:0] irq_req_i,
	output logic irq_take_o,
	output logic [2:0] irq_vec_o,
	// data-space window
	input wire logic ds_we_i,
	input wire logic ds_re_i,
	input wire logic ds_io_op_i,
	input wire logic [15:0] ds_addr_i,
	input wire logic [7:0] ds_wdata_i,
	output logic [7:0] ds_rdata_o,
	output logic ds_io_hit_o,
	output logic ds_ext_hit_o,
	output logic ds_ext_refused_o,
	// software register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	output logic [7:0] cpu_status_flags_o
);
	import crf_pkg::*;

	logic [7:0] gpr_reg [CRF_NREGS];
	logic [7:0] cpu_status_flags_reg;
	logic [7:0] flags_next;
	logic [15:0] instr_reg;
	logic instr_valid_reg;
	logic after_ret_reg;
	logic irq_take;
	logic [2:0] irq_vec;
	logic [7:0] ds_rdata_reg;
	logic [7:0] reg_rdata_reg;
	logic flash_go_reg;
	logic [15:0] push_pc_reg;
	logic push_reg;
	logic ds_ext_ok;
	logic ds_gpr_hit;
	crf_wb_e wb_kind;
	logic copy_bit_src;
	logic [4:0] wb_even;

	function automatic logic [15:0] pair_rd(input logic [7:0] lo, input logic [7:0] hi);
		return {hi, lo};
	endfunction : pair_rd

	function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
		return (a >= lo) && (a <= hi);
	endfunction : in_range

	// combinational reads give same-cycle operands
	assign rd_a_o = gpr_reg[rd_a_sel_i];
	assign rd_b_o = gpr_reg[rd_b_sel_i];
	assign rd_word_o = pair_rd(gpr_reg[{rd_a_sel_i[4:1], 1'b0}], gpr_reg[{rd_a_sel_i[4:1], 1'b1}]);
	assign ptr_x_o = pair_rd(gpr_reg[CRF_PTR_X], gpr_reg[CRF_PTR_X+1]);
	assign ptr_y_o = pair_rd(gpr_reg[CRF_PTR_Y], gpr_reg[CRF_PTR_Y+1]);
	assign ptr_z_o = pair_rd(gpr_reg[CRF_PTR_Z], gpr_reg[CRF_PTR_Z+1]);

	assign wb_kind = !wb_en_i ? CRF_WB_NONE : (wb_word_i ? CRF_WB_WORD : CRF_WB_BYTE);
	assign copy_bit_src = gpr_reg[rd_a_sel_i][bit_sel_i];
	assign wb_even = {wb_sel_i[4:1], 1'b0};

	assign ds_gpr_hit = ds_addr_i < 16'(CRF_NREGS);
	assign ds_io_hit_o = in_range(ds_addr_i, CRF_IO_BASE, CRF_IO_LAST);
	assign ds_ext_hit_o = in_range(ds_addr_i, CRF_EXT_BASE, CRF_EXT_LAST);
	// direct io instructions cannot reach the extended range
	assign ds_ext_ok = ds_ext_hit_o && !ds_io_op_i;
	assign ds_ext_refused_o = ds_ext_hit_o && ds_io_op_i && (ds_we_i || ds_re_i);

	// working registers; alu write-back wins over a data-space store
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			for (int i = 0; i < CRF_NREGS; i++) begin
				gpr_reg[i] <= CRF_REG_RST;
			end
		end else begin
			if (ds_we_i && ds_gpr_hit && !ds_io_op_i) begin
				gpr_reg[ds_addr_i[4:0]] <= ds_wdata_i;
			end
			unique case (wb_kind)
				CRF_WB_NONE: begin
				end
				CRF_WB_BYTE: begin
					gpr_reg[wb_sel_i] <= wb_data_i[7:0];
				end
				CRF_WB_WORD: begin
					gpr_reg[{wb_sel_i[4:1], 1'b0}] <= wb_data_i[7:0];
					gpr_reg[{wb_sel_i[4:1], 1'b1}] <= wb_data_i[15:8];
				end
			endcase
			if (bit_load_from_flag_op_i) begin
				gpr_reg[rd_a_sel_i][bit_sel_i] <= cpu_status_flags_reg[CRF_F_T];
			end
		end
	end

	// flag next value; sign is always derived, never taken from the alu
	always_comb begin
		flags_next = cpu_status_flags_reg;
		if (alu_op_i) begin
			for (int b = 0; b < 8; b++) begin
				if (alu_flag_mask_i[b] && b != CRF_F_I && b != CRF_F_T) begin
					flags_next[b] = alu_flags_i[b];
				end
			end
		end
		if (bit_store_to_flag_op_i) begin
			flags_next[CRF_F_T] = copy_bit_src;
		end
		if (set_global_irq_op_i || return_from_irq_op_i) begin
			flags_next[CRF_F_I] = 1'b1;
		end
		if (clear_global_irq_op_i) begin
			flags_next[CRF_F_I] = 1'b0;
		end
		if (reg_wr_i && reg_addr_i == CRF_ADDR_FLAGS) begin
			flags_next = reg_wdata_i;
		end
		if (ds_we_i && !ds_io_op_i && ds_addr_i == CRF_IO_BASE + 16'(CRF_FLAGS_IO)) begin
			flags_next = ds_wdata_i;
		end
		if (ds_we_i && ds_io_op_i && ds_addr_i[7:0] == CRF_FLAGS_IO) begin
			flags_next = ds_wdata_i;
		end
		// taking an interrupt overrides any enable set in the same cycle
		if (irq_take) begin
			flags_next[CRF_F_I] = 1'b0;
		end
		flags_next[CRF_F_S] = flags_next[CRF_F_N] ^ flags_next[CRF_F_V];
	end

	// same edge as the register write-back above
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			cpu_status_flags_reg <= CRF_FLAGS_RST;
		end else begin
			cpu_status_flags_reg <= flags_next;
		end
	end
	assign cpu_status_flags_o = cpu_status_flags_reg;

	// prefetch stage
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			instr_reg <= 16'h0000;
			instr_valid_reg <= 1'b0;
		end else begin
			instr_reg <= prog_word_i;
			instr_valid_reg <= fetch_en_i;
		end
	end
	assign instr_o = instr_reg;
	assign instr_valid_o = instr_valid_reg;

	// interrupt priority: lowest index first
	always_comb begin
		irq_vec = 3'h0;
		for (int k = CRF_NIRQ - 1; k >= 0; k--) begin
			if (irq_req_i[k]) begin
				irq_vec = 3'(k);
			end
		end
	end
	assign irq_take = cpu_status_flags_reg[CRF_F_I] && (|irq_req_i) && !after_ret_reg
		&& !return_from_irq_op_i;
	assign irq_take_o = irq_take;
	assign irq_vec_o = irq_vec;

	// one main instruction must retire after a return before the next entry
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			after_ret_reg <= 1'b0;
		end else if (return_from_irq_op_i) begin
			after_ret_reg <= 1'b1;
		end else if (instr_valid_reg) begin
			after_ret_reg <= 1'b0;
		end
	end

	// return address push on interrupt entry
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			push_reg <= 1'b0;
			push_pc_reg <= 16'h0000;
		end else begin
			push_reg <= irq_take;
			push_pc_reg <= program_counter_i;
		end
	end
	assign stack_push_o = push_reg;
	assign stack_push_pc_o = push_pc_reg;

	// boot-section check for flash self-write
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			flash_go_reg <= 1'b0;
		end else begin
			flash_go_reg <= flash_self_write_op_i
				&& (flash_target_i >= boot_start_i || program_counter_i >= boot_start_i);
		end
	end
	assign flash_write_go_o = flash_go_reg;

	// data-space read, one cycle latency
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			ds_rdata_reg <= 8'h00;
		end else if (ds_re_i) begin
			if (ds_gpr_hit && !ds_io_op_i) begin
				ds_rdata_reg <= gpr_reg[ds_addr_i[4:0]];
			end else if ((ds_io_op_i && ds_addr_i[7:0] == CRF_FLAGS_IO)
				|| (!ds_io_op_i && ds_addr_i == CRF_IO_BASE + 16'(CRF_FLAGS_IO))) begin
				ds_rdata_reg <= cpu_status_flags_reg;
			end else if (ds_ext_ok) begin
				ds_rdata_reg <= 8'h00;
			end else begin
				ds_rdata_reg <= 8'h00;
			end
		end
	end
	assign ds_rdata_o = ds_rdata_reg;

	// software port read; unmapped reads zero
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			reg_rdata_reg <= 8'h00;
		end else if (reg_rd_i) begin
			if (reg_addr_i == CRF_ADDR_FLAGS) begin
				reg_rdata_reg <= cpu_status_flags_reg;
			end else if (reg_addr_i == CRF_ADDR_PSTAT) begin
				reg_rdata_reg <= {5'h00, after_ret_reg, instr_valid_reg, flash_go_reg};
			end else if (reg_addr_i == CRF_ADDR_VEC) begin
				reg_rdata_reg <= {4'h0, |irq_req_i, irq_vec};
			end else if (reg_addr_i < 8'(CRF_NREGS)) begin
				reg_rdata_reg <= gpr_reg[reg_addr_i[4:0]];
			end else begin
				reg_rdata_reg <= 8'h00;
			end
		end else begin
			reg_rdata_reg <= 8'h00;
		end
	end
	assign reg_rdata_o = reg_rdata_reg;

	// sign consistency holds every cycle
	sign_xor_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		cpu_status_flags_reg[CRF_F_S] == (cpu_status_flags_reg[CRF_F_N] ^ cpu_status_flags_reg[CRF_F_V]))
		else $error("sign flag not n xor v");
	irq_gate_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		!cpu_status_flags_reg[CRF_F_I] |-> !irq_take_o)
		else $error("interrupt taken with global enable clear");
	irq_clear_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		irq_take_o |=> !cpu_status_flags_reg[CRF_F_I])
		else $error("global enable not cleared on entry");
	return_from_irq_op_set_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		return_from_irq_op_i && !irq_take |=> cpu_status_flags_reg[CRF_F_I])
		else $error("global enable not set by return");
	one_after_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		return_from_irq_op_i |=> !irq_take_o)
		else $error("interrupt taken right after return");
	byte_wb_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		wb_en_i && !wb_word_i && !bit_load_from_flag_op_i |=> gpr_reg[$past(wb_sel_i)] == $past(wb_data_i[7:0]))
		else $error("byte write-back lost");
	ptr_z_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		wb_en_i && wb_word_i && wb_sel_i == 5'd30 |=> ptr_z_o == $past(wb_data_i))
		else $error("pointer pair not formed from written word");
	prio_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		irq_take_o && irq_req_i[0] |-> irq_vec_o == 3'h0)
		else $error("lowest vector did not win");
	push_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		irq_take_o |=> stack_push_o && stack_push_pc_o == $past(program_counter_i))
		else $error("return address not pushed");
	tflag_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		bit_store_to_flag_op_i |=> cpu_status_flags_reg[CRF_F_T] == $past(copy_bit_src))
		else $error("bit-copy flag not loaded");
	bld_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		bit_load_from_flag_op_i |=> gpr_reg[$past(rd_a_sel_i)][$past(bit_sel_i)] == $past(cpu_status_flags_reg[CRF_F_T]))
		else $error("bit-copy flag not copied into register");
	wb_word_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		wb_en_i && wb_word_i && !bit_load_from_flag_op_i
		|=> {gpr_reg[$past(wb_even) | 5'd1], gpr_reg[$past(wb_even)]} == $past(wb_data_i))
		else $error("word write-back lost");
	// a flag update a cycle late would let a branch test stale flags
	commit_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		alu_op_i && alu_flag_mask_i == 8'hff && wb_en_i && !wb_word_i
		&& !bit_load_from_flag_op_i && !reg_wr_i && !ds_we_i
		|=> cpu_status_flags_reg[3:0] == $past(alu_flags_i[3:0]) && gpr_reg[$past(wb_sel_i)] == $past(wb_data_i[7:0]))
		else $error("result and flags not committed on one edge");
	fetch_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		fetch_en_i |=> instr_valid_o && instr_o == $past(prog_word_i))
		else $error("prefetched word not presented");
	flash_go_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		flash_self_write_op_i && flash_target_i < boot_start_i && program_counter_i < boot_start_i |=> !flash_write_go_o)
		else $error("self-write from application section went ahead");
	ext_read_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		ds_re_i && ds_io_op_i && ds_ext_hit_o |=> ds_rdata_o == 8'h00)
		else $error("direct io read reached extended io");
	io_flag_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		ds_we_i && ds_io_op_i && ds_addr_i[7:0] == CRF_FLAGS_IO |=> cpu_status_flags_reg[3:0] == $past(ds_wdata_i[3:0]))
		else $error("direct io write missed the flag register");

	irq_cov_c: cover property (@(posedge clock_i) irq_take_o);
	return_from_irq_op_cov_c: cover property (@(posedge clock_i) return_from_irq_op_i ##1 instr_valid_o ##1 irq_take_o);
	word_cov_c: cover property (@(posedge clock_i) wb_en_i && wb_word_i);
	alu_cov_c: cover property (@(posedge clock_i) alu_op_i && wb_en_i);
endmodule : crf_core

// *** hdl/crf_pkg.sv ***
/*
 * crf_pkg: constants shared by the cpu register file and status-flag block.
 * assumes a single cpu clock domain and a synchronous active-high reset.
 */
package crf_pkg;
	localparam int CRF_NREGS = 32;
	localparam int CRF_AW = 5;
	localparam int CRF_DW = 8;
	localparam int CRF_PTR_X = 26;
	localparam int CRF_PTR_Y = 28;
	localparam int CRF_PTR_Z = 30;
	localparam logic [7:0] CRF_FLAGS_RST = 8'h00;
	localparam logic [7:0] CRF_REG_RST = 8'h00;
	// flag bit positions
	localparam int CRF_F_I = 7;
	localparam int CRF_F_T = 6;
	localparam int CRF_F_H = 5;
	localparam int CRF_F_S = 4;
	localparam int CRF_F_V = 3;
	localparam int CRF_F_N = 2;
	localparam int CRF_F_Z = 1;
	localparam int CRF_F_C = 0;
	// data-space map
	localparam logic [15:0] CRF_IO_BASE = 16'h0020;
	localparam logic [15:0] CRF_IO_LAST = 16'h005f;
	localparam logic [15:0] CRF_EXT_BASE = 16'h0060;
	localparam logic [15:0] CRF_EXT_LAST = 16'h00ff;
	localparam logic [7:0] CRF_FLAGS_IO = 8'h3f;
	// register-port addresses of the flag, pipeline-status and interrupt-vector registers
	localparam logic [7:0] CRF_ADDR_FLAGS = 8'h20;
	localparam logic [7:0] CRF_ADDR_PSTAT = 8'h21;
	localparam logic [7:0] CRF_ADDR_VEC = 8'h22;
	localparam int CRF_NIRQ = 8;
	typedef enum logic [2:0] {
		CRF_WB_NONE = 3'b001,
		CRF_WB_BYTE = 3'b010,
		CRF_WB_WORD = 3'b100
	} crf_wb_e;
endpackage : crf_pkg

// *** verif/crf_alu_model.sv ***
/*
 * crf_alu_model: byte adder standing in for the cpu alu, giving sum and flags.
 * assumes its operands come straight from the register file read ports.
 */
`timescale 1ns/1ps
module crf_alu_model (
	input wire logic [7:0] a_i,
	input wire logic [7:0] b_i,
	output logic [7:0] sum_o,
	output logic [7:0] flags_o
);
	logic [8:0] s;
	logic h;
	logic v;
	assign s = {1'b0, a_i} + {1'b0, b_i};
	assign sum_o = s[7:0];
	assign h = ({1'b0, a_i[3:0]} + {1'b0, b_i[3:0]}) > 5'h0f;
	assign v = (a_i[7] == b_i[7]) && (s[7] != a_i[7]);
	// bits 7, 6 and 4 stay zero: the flag register owns them
	assign flags_o = {2'b00, h, 1'b0, v, s[7], s[7:0] == 8'h00, s[8]};
endmodule : crf_alu_model

// *** verif/tb.sv ***
/*
 * tb: self-checking bench for crf_core, one task per scenario.
 * assumes crf_pkg is compiled first and crf_alu_model plays the alu.
 */
`timescale 1ns/1ps
module tb;
	import crf_pkg::*;
	logic clock_i, sys_rst_i, wb_en_i, wb_word_i, alu_op_i, bit_store_to_flag_op_i, bit_load_from_flag_op_i;
	logic set_global_irq_op_i, clear_global_irq_op_i, return_from_irq_op_i, fetch_en_i, flash_self_write_op_i;
	logic ds_we_i, ds_re_i, ds_io_op_i, reg_wr_i, reg_rd_i, use_alu, instr_valid_o, flash_write_go_o;
	logic stack_push_o, irq_take_o, ds_io_hit_o, ds_ext_hit_o, ds_ext_refused_o;
	logic [4:0] rd_a_sel_i, rd_b_sel_i, wb_sel_i;
	logic [2:0] bit_sel_i, irq_vec_o;
	logic [7:0] rd_a_o, rd_b_o, alu_flags_i, alu_flag_mask_i, irq_req_i, ds_wdata_i, ds_rdata_o, p_sum, d;
	logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, cpu_status_flags_o;
	logic [15:0] rd_word_o, wb_data_i, wb_data_t, ptr_x_o, ptr_y_o, ptr_z_o, prog_word_i, instr_o, ds_addr_i;
	logic [15:0] program_counter_i, boot_start_i, flash_target_i, stack_push_pc_o;
	int miscompares, comparisons;
	assign wb_data_i = use_alu ? {8'h00, p_sum} : wb_data_t;
	crf_alu_model i_alu (.a_i(rd_a_o), .b_i(rd_b_o), .sum_o(p_sum), .flags_o(alu_flags_i));
	crf_core i_dut (.clock_i, .sys_rst_i, .rd_a_sel_i, .rd_b_sel_i, .rd_a_o, .rd_b_o, .rd_word_o, .wb_sel_i,
		.wb_en_i, .wb_word_i, .wb_data_i, .alu_op_i, .alu_flags_i, .alu_flag_mask_i, .bit_store_to_flag_op_i,
		.bit_load_from_flag_op_i, .bit_sel_i, .set_global_irq_op_i, .clear_global_irq_op_i,
		.return_from_irq_op_i, .ptr_x_o, .ptr_y_o, .ptr_z_o, .fetch_en_i, .prog_word_i, .instr_o,
		.instr_valid_o, .program_counter_i, .boot_start_i, .flash_self_write_op_i, .flash_target_i,
		.flash_write_go_o, .stack_push_pc_o, .stack_push_o, .irq_req_i, .irq_take_o, .irq_vec_o, .ds_we_i,
		.ds_re_i, .ds_io_op_i, .ds_addr_i, .ds_wdata_i, .ds_rdata_o, .ds_io_hit_o, .ds_ext_hit_o,
		.ds_ext_refused_o, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .cpu_status_flags_o);
	initial begin
		clock_i = 1'b0;
		forever #50 clock_i = ~clock_i;
	end
	task automatic chk(input string what, input logic [15:0 ] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic end_sim;
		if (miscompares == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : end_sim
	// fill pattern for the register sweep
	function automatic logic [7:0] fv(input int i);
		return 8'(i * 37 + 5);
	endfunction : fv
	task automatic wb(input logic [4:0] s, input logic [15:0] v, input logic w);
		@(posedge clock_i);
		wb_sel_i <= s;
		wb_data_t <= v;
		wb_word_i <= w;
		wb_en_i <= 1'b1;
		@(posedge clock_i);
		wb_en_i <= 1'b0;
	endtask : wb
	task automatic sel(input logic [4:0] a, input logic [4:0] b);
		@(posedge clock_i);
		rd_a_sel_i <= a;
		rd_b_sel_i <= b;
		#1;
	endtask : sel
	task automatic rd_reg(input logic [7:0] a);
		@(posedge clock_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clock_i);
		reg_rd_i <= 1'b0;
		#1 d = reg_rdata_o;
	endtask : rd_reg
	task automatic ds_rd(input logic [15:0] a, input logic io);
		@(posedge clock_i);
		ds_addr_i <= a;
		ds_io_op_i <= io;
		ds_re_i <= 1'b1;
		@(posedge clock_i);
		ds_re_i <= 1'b0;
		#1 d = ds_rdata_o;
	endtask : ds_rd
	task automatic alu(input logic [4:0] a, input logic [4:0] b, input logic [7:0] m);
		@(posedge clock_i);
		{rd_a_sel_i, rd_b_sel_i, wb_sel_i, wb_word_i} <= {a, b, 5'd3, 1'b0};
		{wb_en_i, use_alu, alu_op_i, alu_flag_mask_i} <= {3'b111, m};
		@(posedge clock_i);
		{wb_en_i, use_alu, alu_op_i} <= 3'b000;
		#1;
	endtask : alu
	task automatic t_regs;
		for (int i = 0; i < CRF_NREGS; i++) wb(5'(i), {8'h00, fv(i)}, 1'b0);
		for (int i = 0; i < CRF_NREGS; i += 2) begin
			sel(5'(i), 5'(i + 1));
			chk("rd_a", {8'h00, fv(i)}, {8'h00, rd_a_o});
			chk("rd_b", {8'h00, fv(i + 1)}, {8'h00, rd_b_o});
			chk("rd_word", {fv(i + 1), fv(i)}, rd_word_o);
		end
		wb(5'd26, 16'hbeef, 1'b1);
		wb(5'd28, 16'h1234, 1'b1);
		wb(5'd30, 16'h5678, 1'b1);
		#1 chk("ptr_x", 16'hbeef, ptr_x_o);
		chk("ptr_y", 16'h1234, ptr_y_o);
		chk("ptr_z", 16'h5678, ptr_z_o);
		wb(5'd1, 16'h007f, 1'b0);
		wb(5'd2, 16'h0001, 1'b0);
	endtask : t_regs
	task automatic t_alu;
		// 7f+01: half carry, overflow, negative, so sign clear
		alu(5'd1, 5'd2, 8'hff);
		chk("flags add", 16'h002c, {8'h00, cpu_status_flags_o});
		sel(5'd3, 5'd0);
		chk("sum", 16'h0080, {8'h00, rd_a_o});
		// 80+80 with H masked off: H kept, V Z C set, S = N ^ V
		alu(5'd3, 5'd3, 8'h0f);
		chk("flags mask", 16'h003b, {8'h00, cpu_status_flags_o});
	endtask : t_alu
	task automatic t_bit;
		wb(5'd3, 16'h0080, 1'b0);
		@(posedge clock_i);
		{rd_a_sel_i, bit_sel_i, bit_store_to_flag_op_i} <= {5'd3, 3'd7, 1'b1};
		@(posedge clock_i);
		{rd_a_sel_i, bit_sel_i, bit_store_to_flag_op_i, bit_load_from_flag_op_i} <= {5'd4, 3'd1, 2'b01};
		#1 chk("t set", 16'h007b, {8'h00, cpu_status_flags_o});
		@(posedge clock_i);
		bit_load_from_flag_op_i <= 1'b0;
		#1 chk("bit load", {8'h00, fv(4) | 8'h02}, {8'h00, rd_a_o});
	endtask : t_bit
	task automatic t_fetch;
		@(posedge clock_i);
		{fetch_en_i, prog_word_i, flash_self_write_op_i} <= {1'b1, 16'habcd, 1'b1};
		{boot_start_i, program_counter_i, flash_target_i} <= {16'hf000, 16'hf010, 16'h0100};
		@(posedge clock_i);
		{fetch_en_i, program_counter_i} <= {1'b0, 16'h0010};
		#1 chk("instr", 16'habcd, instr_o);
		chk("instr valid", 16'h0001, {15'h0, instr_valid_o});
		chk("go boot", 16'h0001, {15'h0, flash_write_go_o});
		@(posedge clock_i);
		flash_self_write_op_i <= 1'b0;
		#1 chk("go app", 16'h0000, {15'h0, flash_write_go_o});
	endtask : t_fetch
	task automatic t_irq;
		@(posedge clock_i);
		irq_req_i <= 8'h0c;
		#1 chk("take gated", 16'h0000, {15'h0, irq_take_o});
		@(posedge clock_i);
		set_global_irq_op_i <= 1'b1;
		@(posedge clock_i);
		set_global_irq_op_i <= 1'b0;
		#1 chk("take", 16'h0001, {15'h0, irq_take_o});
		chk("vec", 16'h0002, {13'h0, irq_vec_o});
		@(posedge clock_i);
		return_from_irq_op_i <= 1'b1;
		#1 chk("entry i", 16'h007b, {8'h00, cpu_status_flags_o});
		chk("push", 16'h0001, {15'h0, stack_push_o});
		chk("push pc", 16'h0010, stack_push_pc_o);
		@(posedge clock_i);
		return_from_irq_op_i <= 1'b0;
		#1 chk("ret i", 16'h00fb, {8'h00, cpu_status_flags_o});
		chk("take held", 16'h0000, {15'h0, irq_take_o});
		@(posedge clock_i);
		fetch_en_i <= 1'b1;
		@(posedge clock_i);
		fetch_en_i <= 1'b0;
		#1 chk("take wait", 16'h0000, {15'h0, irq_take_o});
		@(posedge clock_i);
		#1 chk("take after", 16'h0001, {15'h0, irq_take_o});
		@(posedge clock_i);
		{irq_req_i, set_global_irq_op_i} <= {8'h00, 1'b1};
		@(posedge clock_i);
		{set_global_irq_op_i, clear_global_irq_op_i} <= 2'b01;
		#1 chk("set i", 16'h00fb, {8'h00, cpu_status_flags_o});
		@(posedge clock_i);
		clear_global_irq_op_i <= 1'b0;
		#1 chk("clear i", 16'h007b, {8'h00, cpu_status_flags_o});
	endtask : t_irq
	task automatic t_ds;
		@(posedge clock_i);
		{ds_we_i, ds_io_op_i, ds_addr_i, ds_wdata_i} <= {2'b10, 16'h0005, 8'h3c};
		@(posedge clock_i);
		ds_we_i <= 1'b0;
		ds_rd(16'h0005, 1'b0);
		chk("ds gpr", 16'h003c, {8'h00, d});
		ds_rd(16'h005f, 1'b0);
		chk("ds flags", 16'h007b, {8'h00, d});
		ds_rd(16'h003f, 1'b1);
		chk("io flags", 16'h007b, {8'h00, d});
		chk("io hit", 16'h0001, {15'h0, ds_io_hit_o});
		ds_rd(16'h0060, 1'b0);
		chk("ext hit", 16'h0002, {14'h0, ds_ext_hit_o, ds_ext_refused_o});
		@(posedge clock_i);
		{ds_io_op_i, ds_re_i} <= 2'b11;
		#1 chk("ext refused", 16'h0001, {15'h0, ds_ext_refused_o});
		@(posedge clock_i);
		{ds_re_i, ds_we_i, ds_addr_i, ds_wdata_i} <= {2'b01, 16'h003f, 8'h04};
		#1 chk("ext read", 16'h0000, {8'h00, ds_rdata_o});
		@(posedge clock_i);
		ds_we_i <= 1'b0;
		#1 chk("io write", 16'h0014, {8'h00, cpu_status_flags_o});
	endtask : t_ds
	task automatic t_port;
		@(posedge clock_i);
		{reg_addr_i, reg_wdata_i, reg_wr_i, fetch_en_i} <= {CRF_ADDR_FLAGS, 8'h81, 2'b11};
		@(posedge clock_i);
		reg_wr_i <= 1'b0;
		rd_reg(CRF_ADDR_FLAGS);
		chk("port flags", 16'h0081, {8'h00, d});
		rd_reg(CRF_ADDR_PSTAT);
		chk("port pstat", 16'h0002, {8'h00, d});
		rd_reg(8'h05);
		chk("port gpr", 16'h003c, {8'h00, d});
		rd_reg(8'h80);
		chk("port unmapped", 16'h0000, {8'h00, d});
		@(posedge clock_i);
		{fetch_en_i, irq_req_i} <= {1'b0, 8'h30};
		rd_reg(CRF_ADDR_VEC);
		chk("port vec", 16'h000c, {8'h00, d});
	endtask : t_port
	initial begin
		#(100 * 5000);
		miscompares++;
		end_sim();
	end
	initial begin
		{wb_en_i, wb_word_i, alu_op_i, bit_store_to_flag_op_i, bit_load_from_flag_op_i, use_alu} = '0;
		{set_global_irq_op_i, clear_global_irq_op_i, return_from_irq_op_i, fetch_en_i} = '0;
		{flash_self_write_op_i, ds_we_i, ds_re_i, ds_io_op_i, reg_wr_i, reg_rd_i, rd_a_sel_i, rd_b_sel_i} = '0;
		{wb_sel_i, bit_sel_i, alu_flag_mask_i, irq_req_i, ds_wdata_i, reg_addr_i, reg_wdata_i} = '0;
		{wb_data_t, prog_word_i, ds_addr_i, program_counter_i, boot_start_i, flash_target_i} = '0;
		sys_rst_i = 1'b1;
		repeat (20) @(posedge clock_i);
		sys_rst_i <= 1'b0;
		#1 chk("rst flags", {8'h00, CRF_FLAGS_RST}, {8'h00, cpu_status_flags_o});
		chk("rst gpr", {8'h00, CRF_REG_RST}, {8'h00, rd_a_o});
		t_regs();
		t_alu();
		t_bit();
		t_fetch();
		t_irq();
		t_ds();
		t_port();
		end_sim();
	end
endmodule : tb
